// File: rtl/poe_class_pkg.sv
// constants, codes and types for the per-port class and power control
// assumes one 50 MHz clock and an 8-bit register port with 4-bit address
package poe_class_pkg;
  localparam int CLK_MHZ = 50;
  // classification pulse time, typical
  localparam int CLASS_TIME_US = 12000;
  localparam int CLASS_CYCLES = CLASS_TIME_US * CLK_MHZ;
  // pause at the mark voltage between the two class pulses
  localparam int MARK_TIME_US = 100;
  localparam int MARK_CYCLES = MARK_TIME_US * CLK_MHZ;
  localparam int START_TIME_US = 60000;
  localparam int START_CYCLES = START_TIME_US * CLK_MHZ;
  localparam int CUT_TIME_US = 60000;
  localparam int CUT_CYCLES = CUT_TIME_US * CLK_MHZ;
  localparam int LIMIT_TIME_US = 1000;
  localparam int LIMIT_CYCLES = LIMIT_TIME_US * CLK_MHZ;
  // cut timer counts up this many times faster than it counts down
  localparam int CUT_UP_STEP = 16;
  // analog levels the port stage is told to use
  localparam int CLASS_VOLT_MV = 18000;
  localparam int MARK_VOLT_MV = 9000;
  localparam int INRUSH_MA = 450;
  // register offsets
  localparam logic [3:0] REG_CONTROL = 4'h0;
  localparam logic [3:0] REG_COMMAND = 4'h1;
  localparam logic [3:0] REG_STATUS = 4'h2;
  localparam logic [3:0] REG_HP_STATUS = 4'h3;
  localparam logic [3:0] REG_LIMIT = 4'h4;
  localparam logic [3:0] REG_CUT = 4'h5;
  localparam logic [3:0] REG_FAULT = 4'h6;
  // field positions
  localparam int CTRL_CLASS_EN = 0;
  localparam int CTRL_PINGPONG = 1;
  localparam int CTRL_QUARTER_OHM = 2;
  localparam int CTRL_MANUAL = 3;
  localparam int CMD_CLASSIFY = 0;
  localparam int CMD_POWER_ON = 1;
  localparam int CMD_POWER_OFF = 2;
  localparam int STAT_POWERED = 4;
  localparam int STAT_STANDALONE = 5;
  localparam int FLT_START = 0;
  localparam int FLT_CUT = 1;
  localparam int FLT_LIMIT = 2;
  // hard limit codes, 425 mA and 850 mA for each sense scaling
  localparam logic [7:0] LIM425_HALF = 8'h00;
  localparam logic [7:0] LIM850_HALF = 8'h40;
  localparam logic [7:0] LIM425_QUARTER = 8'h80;
  localparam logic [7:0] LIM850_QUARTER = 8'hC0;
  // cut threshold codes per class in standalone mode
  localparam logic [6:0] CUT_CLASS1 = 7'h0B;
  localparam logic [6:0] CUT_CLASS2 = 7'h15;
  localparam logic [6:0] CUT_CLASS3 = 7'h26;
  localparam logic [6:0] CUT_CLASS4 = 7'h40;
  localparam logic [6:0] CUT_RESET = 7'h26;
  typedef enum logic [2:0] {
    CLASS_0 = 3'h0, CLASS_1 = 3'h1, CLASS_2 = 3'h2, CLASS_3 = 3'h3,
    CLASS_4 = 3'h4, CLASS_NONE = 3'h7
  } class_type;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CLASS1 = 3'h1, ST_MARK = 3'h2, ST_CLASS2 = 3'h3,
    ST_INRUSH = 3'h4, ST_POWERED = 3'h5
  } state_type;
endpackage : poe_class_pkg

// File: rtl/overload_timer_if.sv
// signals between the port sequencer and its overload timers
// assumes both ends sit on the same clock
interface overload_timer_if;
  logic active;
  logic overCut;
  logic overLimit;
  logic cutExpired;
  logic limitExpired;
  modport ctrl (output active, output overCut, output overLimit,
    input cutExpired, input limitExpired);
  modport timer (input active, input overCut, input overLimit,
    output cutExpired, output limitExpired);
endinterface : overload_timer_if

// File: rtl/overload_timer.sv
// cut timer (up/down) and limit timer of one powered port
// assumes comparator levels already synchronous to clock
module overload_timer #(
  parameter int CUT_CYCLES = poe_class_pkg::CUT_CYCLES,
  parameter int LIMIT_CYCLES = poe_class_pkg::LIMIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  overload_timer_if.timer tif
);
  localparam int CUT_TOP = CUT_CYCLES * poe_class_pkg::CUT_UP_STEP;
  localparam int CW = $clog2(CUT_TOP + 1);
  localparam int LW = $clog2(LIMIT_CYCLES + 1);
  logic [CW-1:0] cutCount;
  logic [LW-1:0] limitCount;

  // up by the step while above cut, down by one below: duty over ~6% trips
  // cut timer runs
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      cutCount <= '0;
    else if (!tif.active)
      cutCount <= '0;
    else if (tif.overCut)
    begin
      if (cutCount >= CW'(CUT_TOP - poe_class_pkg::CUT_UP_STEP))
        cutCount <= CW'(CUT_TOP);
      else
        cutCount <= cutCount + CW'(poe_class_pkg::CUT_UP_STEP);
    end
    else if (cutCount != '0)
      cutCount <= cutCount - CW'(1);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      limitCount <= '0;
    else if (!tif.active || !tif.overLimit)
      limitCount <= '0;
    else if (limitCount != LW'(LIMIT_CYCLES))
      limitCount <= limitCount + LW'(1);
  end

  assign tif.cutExpired = (cutCount == CW'(CUT_TOP));
  assign tif.limitExpired = (limitCount == LW'(LIMIT_CYCLES));

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_cutDown;
    tif.active && !tif.overCut && cutCount != '0 && !$past(tif.overCut)
      |=> cutCount == $past(cutCount) - CW'(1);
  endproperty
  a_cutDown: assert property (p_cutDown) else $error("cut timer slow decay wrong");
  property p_cutUp;
    tif.active && tif.overCut && cutCount < CW'(CUT_TOP / 2)
      |=> cutCount == $past(cutCount) + CW'(poe_class_pkg::CUT_UP_STEP);
  endproperty
  a_cutUp: assert property (p_cutUp) else $error("cut timer fast count wrong");
endmodule : overload_timer

// File: rtl/poe_port_class_power_ctrl.sv
// one port: classification sequence, inrush with start timer, two thresholds
// assumes analog stage gives class result, comparator levels and detect pulse
// synchronous to clock; host reaches registers over a plain strobe port

module poe_port_class_power_ctrl #(
  parameter int CLASS_CYCLES = poe_class_pkg::CLASS_CYCLES,
  parameter int MARK_CYCLES = poe_class_pkg::MARK_CYCLES,
  parameter int START_CYCLES = poe_class_pkg::START_CYCLES,
  parameter int CUT_CYCLES = poe_class_pkg::CUT_CYCLES,
  parameter int LIMIT_CYCLES = poe_class_pkg::LIMIT_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regReadData,
  input wire logic standalonePin,
  input wire logic shutdown,
  input wire logic detectGood,
  input wire logic [2:0] classCurrent,
  input wire logic overCut,
  input wire logic overLimit,
  input wire logic inrushDone,
  output logic classVoltageOn,
  output logic markVoltageOn,
  output logic gateOn,
  output logic inrushRegulate,
  output logic [7:0] hardCurrentLimit,
  output logic [6:0] overloadCutThreshold,
  output logic quarterOhm,
  output logic restartDetect
);
  localparam int PW = 32;
  poe_class_pkg::state_type state, nextState;
  poe_class_pkg::class_type classField, measured;
  logic [PW-1:0] phaseCount;
  logic standalone, strapTaken;
  logic classEnable, pingPong, manualBit;
  logic hpFlag;
  logic [7:0] hardLimit;
  logic [6:0] cutThreshold;
  logic [2:0] faultFlags, faultSet;
  logic classEnd, markEnd, startExpire;
  logic cmdClassify, cmdPowerOn, cmdPowerOff, manualMode, portOn, turnOff;
  logic [7:0] lim425, lim850;
  overload_timer_if tif();

  overload_timer #(
    .CUT_CYCLES(CUT_CYCLES),
    .LIMIT_CYCLES(LIMIT_CYCLES)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .tif(tif)
  );

  // command strobes only live for the write cycle
  assign cmdClassify = regWrite && regAddr == poe_class_pkg::REG_COMMAND
    && regWriteData[poe_class_pkg::CMD_CLASSIFY];
  assign cmdPowerOn = regWrite && regAddr == poe_class_pkg::REG_COMMAND
    && regWriteData[poe_class_pkg::CMD_POWER_ON];
  assign cmdPowerOff = regWrite && regAddr == poe_class_pkg::REG_COMMAND
    && regWriteData[poe_class_pkg::CMD_POWER_OFF];
  // the strap overrides the manual bit
  assign manualMode = manualBit && !standalone;
  assign portOn = state == poe_class_pkg::ST_INRUSH || state == poe_class_pkg::ST_POWERED;
  assign turnOff = portOn && nextState == poe_class_pkg::ST_IDLE;
  assign lim425 = quarterOhm ? poe_class_pkg::LIM425_QUARTER : poe_class_pkg::LIM425_HALF;
  assign lim850 = quarterOhm ? poe_class_pkg::LIM850_QUARTER : poe_class_pkg::LIM850_HALF;

  // out-of-range current reads as class 0
  assign measured = (classCurrent > 3'h4) ? poe_class_pkg::CLASS_0
    : poe_class_pkg::class_type'(classCurrent);

  assign classEnd = phaseCount == PW'(CLASS_CYCLES - 1);
  assign markEnd = phaseCount == PW'(MARK_CYCLES - 1);
  assign startExpire = phaseCount == PW'(START_CYCLES - 1);

  // strap is caught by a clocked process after reset release, not by the reset
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      standalone <= 1'b0;
      strapTaken <= 1'b0;
    end
    else if (!strapTaken)
    begin
      standalone <= standalonePin;
      strapTaken <= 1'b1;
    end
  end

  // control register; class enable defaults from the strap
  // class enable from strap
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      classEnable <= 1'b0;
      pingPong <= 1'b0;
      quarterOhm <= 1'b0;
      manualBit <= 1'b0;
    end
    else if (!strapTaken)
      classEnable <= standalonePin;
    else if (regWrite && regAddr == poe_class_pkg::REG_CONTROL)
    begin
      classEnable <= regWriteData[poe_class_pkg::CTRL_CLASS_EN];
      pingPong <= regWriteData[poe_class_pkg::CTRL_PINGPONG];
      quarterOhm <= regWriteData[poe_class_pkg::CTRL_QUARTER_OHM];
      manualBit <= regWriteData[poe_class_pkg::CTRL_MANUAL];
    end
  end

  // sequencer
  always_comb
  begin
    nextState = state;
    faultSet = 3'h0;
    case (state)
      poe_class_pkg::ST_IDLE:
        if (shutdown)
          nextState = poe_class_pkg::ST_IDLE;
        else if (cmdPowerOn)
          nextState = poe_class_pkg::ST_INRUSH;
        else if (classEnable && strapTaken
                 && (manualMode ? cmdClassify : detectGood))
          nextState = poe_class_pkg::ST_CLASS1;
        else if (standalone && detectGood)
          nextState = poe_class_pkg::ST_INRUSH;
      poe_class_pkg::ST_CLASS1:
        if (shutdown)
          nextState = poe_class_pkg::ST_IDLE;
        else if (classEnd)
        begin
          if (measured == poe_class_pkg::CLASS_4 && pingPong)
            nextState = poe_class_pkg::ST_MARK;
          else if (standalone)
            nextState = poe_class_pkg::ST_INRUSH;
          else
            nextState = poe_class_pkg::ST_IDLE;
        end
      poe_class_pkg::ST_MARK:
        if (shutdown)
          nextState = poe_class_pkg::ST_IDLE;
        else if (markEnd)
          nextState = poe_class_pkg::ST_CLASS2;
      poe_class_pkg::ST_CLASS2:
        if (shutdown)
          nextState = poe_class_pkg::ST_IDLE;
        else if (classEnd)
        begin
          if (standalone && measured == poe_class_pkg::CLASS_4)
            nextState = poe_class_pkg::ST_INRUSH;
          else
            nextState = poe_class_pkg::ST_IDLE;
        end
      poe_class_pkg::ST_INRUSH:
        if (shutdown || cmdPowerOff)
          nextState = poe_class_pkg::ST_IDLE;
        else if (inrushDone)
          nextState = poe_class_pkg::ST_POWERED;
        else if (startExpire)
        begin
          nextState = poe_class_pkg::ST_IDLE;
          faultSet[poe_class_pkg::FLT_START] = 1'b1;
        end
      poe_class_pkg::ST_POWERED:
        if (shutdown || cmdPowerOff)
          nextState = poe_class_pkg::ST_IDLE;
        else if (tif.cutExpired)
        begin
          nextState = poe_class_pkg::ST_IDLE;
          faultSet[poe_class_pkg::FLT_CUT] = 1'b1;
        end
        else if (tif.limitExpired)
        begin
          nextState = poe_class_pkg::ST_IDLE;
          faultSet[poe_class_pkg::FLT_LIMIT] = 1'b1;
        end
      default:
        nextState = poe_class_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      state <= poe_class_pkg::ST_IDLE;
    else
      state <= nextState;
  end

  // phase counter restarts on each state change
  // start timer during inrush
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      phaseCount <= '0;
    else if (nextState != state)
      phaseCount <= '0;
    else if (state != poe_class_pkg::ST_IDLE && state != poe_class_pkg::ST_POWERED)
      phaseCount <= phaseCount + PW'(1);
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      classField <= poe_class_pkg::CLASS_NONE;
    else if (classEnd && (state == poe_class_pkg::ST_CLASS1
                          || state == poe_class_pkg::ST_CLASS2))
      classField <= measured;
  end

  // flag cleared when a new sequence begins, so it reflects this PD only
  // second cycle flag
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      hpFlag <= 1'b0;
    else if (nextState == poe_class_pkg::ST_CLASS2)
      hpFlag <= 1'b1;
    else if (state == poe_class_pkg::ST_IDLE && nextState == poe_class_pkg::ST_CLASS1)
      hpFlag <= 1'b0;
  end

  // thresholds: host writes any time, even while powered, except in a turn-off or standalone class-end cycle
  // live threshold writes
  // limit back to 425 on off
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hardLimit <= poe_class_pkg::LIM425_HALF;
      cutThreshold <= poe_class_pkg::CUT_RESET;
    end
    else if (turnOff)
      hardLimit <= lim425;
    else if (standalone && classEnd && nextState == poe_class_pkg::ST_INRUSH)
    begin
      case (measured)
        poe_class_pkg::CLASS_1: cutThreshold <= poe_class_pkg::CUT_CLASS1;
        poe_class_pkg::CLASS_2: cutThreshold <= poe_class_pkg::CUT_CLASS2;
        poe_class_pkg::CLASS_4: cutThreshold <= poe_class_pkg::CUT_CLASS4;
        default: cutThreshold <= poe_class_pkg::CUT_CLASS3;
      endcase
      hardLimit <= (measured == poe_class_pkg::CLASS_4) ? lim850 : lim425;
    end
    else if (regWrite && regAddr == poe_class_pkg::REG_LIMIT)
      hardLimit <= regWriteData;
    else if (regWrite && regAddr == poe_class_pkg::REG_CUT)
      cutThreshold <= regWriteData[6:0];
  end

  // sticky faults, write one to clear; a new fault beats the clear
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      faultFlags <= 3'h0;
    else if (regWrite && regAddr == poe_class_pkg::REG_FAULT)
      faultFlags <= (faultFlags & ~regWriteData[2:0]) | faultSet;
    else
      faultFlags <= faultFlags | faultSet;
  end

  // drive outputs from flops; limit forced low while inrush runs
  // inrush limit forced
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hardCurrentLimit <= poe_class_pkg::LIM425_HALF;
      overloadCutThreshold <= poe_class_pkg::CUT_RESET;
      restartDetect <= 1'b0;
    end
    else
    begin
      hardCurrentLimit <= (nextState == poe_class_pkg::ST_INRUSH) ? lim425 : hardLimit;
      overloadCutThreshold <= cutThreshold;
      restartDetect <= state == poe_class_pkg::ST_CLASS2 && classEnd && !shutdown
        && standalone && measured != poe_class_pkg::CLASS_4;
    end
  end

  assign classVoltageOn = state == poe_class_pkg::ST_CLASS1 || state == poe_class_pkg::ST_CLASS2;
  assign markVoltageOn = state == poe_class_pkg::ST_MARK;
  assign gateOn = portOn;
  assign inrushRegulate = state == poe_class_pkg::ST_INRUSH;
  assign tif.active = state == poe_class_pkg::ST_POWERED;
  assign tif.overCut = overCut;
  assign tif.overLimit = overLimit;

  // read data one cycle after the strobe, zero elsewhere and when unmapped
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      regReadData <= 8'h00;
    else if (!regRead)
      regReadData <= 8'h00;
    else
      case (regAddr)
        poe_class_pkg::REG_CONTROL:
          regReadData <= {4'h0, manualBit, quarterOhm, pingPong, classEnable};
        poe_class_pkg::REG_STATUS:
          regReadData <= {2'h0, standalone, portOn, 1'b0, classField};
        poe_class_pkg::REG_HP_STATUS: regReadData <= {7'h00, hpFlag};
        poe_class_pkg::REG_LIMIT: regReadData <= hardLimit;
        poe_class_pkg::REG_CUT: regReadData <= {1'b0, cutThreshold};
        poe_class_pkg::REG_FAULT: regReadData <= {5'h00, faultFlags};
        default: regReadData <= 8'h00;
      endcase
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_autoClass;
    state == poe_class_pkg::ST_IDLE && !shutdown && !manualMode && detectGood
      && classEnable && strapTaken && !cmdPowerOn |=> classVoltageOn;
  endproperty
  a_autoClass: assert property (p_autoClass) else $error("no class after detect");
  property p_classStore;
    state == poe_class_pkg::ST_CLASS1 && classEnd
      |=> classField == $past(measured);
  endproperty
  a_classStore: assert property (p_classStore) else $error("class not stored");
  property p_noClassOff;
    state == poe_class_pkg::ST_IDLE && !classEnable |=> !classVoltageOn;
  endproperty
  a_noClassOff: assert property (p_noClassOff) else $error("class while disabled");
  property p_mark;
    state == poe_class_pkg::ST_CLASS1 && classEnd && !shutdown && pingPong
      && measured == poe_class_pkg::CLASS_4 |=> markVoltageOn && !classVoltageOn;
  endproperty
  a_mark: assert property (p_mark) else $error("no mark after class 4");
  property p_hpFlag;
    $rose(state == poe_class_pkg::ST_CLASS2) |-> hpFlag;
  endproperty
  a_hpFlag: assert property (p_hpFlag) else $error("second cycle flag missing");
  property p_skip;
    state == poe_class_pkg::ST_CLASS1 && classEnd
      && measured != poe_class_pkg::CLASS_4 |=> !markVoltageOn;
  endproperty
  a_skip: assert property (p_skip) else $error("second cycle on type 1");
  property p_invalid;
    state == poe_class_pkg::ST_CLASS2 && classEnd && !shutdown && standalone
      && measured != poe_class_pkg::CLASS_4 |=> restartDetect && !gateOn ##1 !restartDetect;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid pair powered");
  property p_inrushLimit;
    inrushRegulate [*2] |-> hardCurrentLimit == lim425;
  endproperty
  a_inrushLimit: assert property (p_inrushLimit) else $error("inrush limit not 425");
  property p_offLimit;
    turnOff |=> hardLimit == $past(lim425) && !gateOn;
  endproperty
  a_offLimit: assert property (p_offLimit) else $error("limit not reset at off");
  property p_startFault;
    inrushRegulate && startExpire && !inrushDone && !shutdown && !cmdPowerOff
      |=> !gateOn && faultFlags[poe_class_pkg::FLT_START];
  endproperty
  a_startFault: assert property (p_startFault) else $error("start timeout missed");
  property p_cutFault;
    state == poe_class_pkg::ST_POWERED && tif.cutExpired && !shutdown && !cmdPowerOff
      |=> !gateOn && faultFlags[poe_class_pkg::FLT_CUT];
  endproperty
  a_cutFault: assert property (p_cutFault) else $error("cut expiry missed");
endmodule : poe_port_class_power_ctrl

// File: verif/pd_model.sv
// powered device stand-in: class current per pulse, inrush end
// assumes levels from the port controller, one clock
module pd_model (
  input wire logic clock,
  input wire logic classVoltageOn,
  input wire logic markVoltageOn,
  input wire logic gateOn,
  input wire logic [2:0] firstClass,
  input wire logic [2:0] secondClass,
  input wire logic chargeOk,
  output logic [2:0] classCurrent,
  output logic inrushDone
);
  timeunit 1ns;
  timeprecision 1ns;
  logic afterMark = 1'b0;
  logic [3:0] onCount = 4'h0;
  // mark step selects the second answer; outside pulses the reading wanders
  always_ff @(posedge clock)
  begin
    if (markVoltageOn)
      afterMark <= 1'b1;
    else if (!classVoltageOn)
      afterMark <= 1'b0;
    onCount <= gateOn ? onCount + 4'h1 : 4'h0;
  end
  assign classCurrent = classVoltageOn ? (afterMark ? secondClass : firstClass) : onCount[2:0];
  // charging ends only when the test allows it, a one-cycle pulse
  assign inrushDone = gateOn & chargeOk & (onCount == 4'h3);
endmodule : pd_model

// File: verif/poe_port_class_power_ctrl_tb_top.sv
// self-checking bench for the port class and power controller
// assumes the package and the device stand-in compile first
module poe_port_class_power_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWriteData = 8'h00;
  logic regWrite = 1'b0, regRead = 1'b0, standalonePin = 1'b0, detectGood = 1'b0;
  logic overCut = 1'b0, overLimit = 1'b0, chargeOk = 1'b0, shutdown = 1'b0;
  logic [2:0] firstClass = 3'h0, secondClass = 3'h0, classCurrent;
  logic [7:0] regReadData, hardCurrentLimit, got;
  logic [6:0] overloadCutThreshold;
  logic classVoltageOn, markVoltageOn, gateOn, inrushRegulate, quarterOhm, restartDetect;
  logic inrushDone;
  int seed = 37819;
  int badCount = 0, nTests = 0, restarts = 0, c;
  poe_port_class_power_ctrl #(.CLASS_CYCLES(8), .MARK_CYCLES(4), .START_CYCLES(16),
    .CUT_CYCLES(8), .LIMIT_CYCLES(4)) uut (.clock, .nrst, .regAddr, .regWriteData,
    .regWrite, .regRead, .regReadData, .standalonePin, .shutdown, .detectGood,
    .classCurrent, .overCut, .overLimit, .inrushDone, .classVoltageOn, .markVoltageOn,
    .gateOn, .inrushRegulate, .hardCurrentLimit, .overloadCutThreshold, .quarterOhm,
    .restartDetect);
  pd_model pd (.clock, .classVoltageOn, .markVoltageOn, .gateOn, .firstClass,
    .secondClass, .chargeOk, .classCurrent, .inrushDone);
  // free-running clock and a count of restart pulses
  initial forever #10 clock = ~clock;
  always @(posedge clock) if (restartDetect === 1'b1) restarts++;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    nTests++;
    if (seen !== exp)
    begin
      badCount++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic go(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : go
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 got = regReadData;
  endtask : rd
  task automatic det();
    @(posedge clock);
    detectGood <= 1'b1;
    @(posedge clock);
    detectGood <= 1'b0;
  endtask : det
  // strap only counts at reset release, so a mode change needs a reset
  task automatic rst(input logic strap);
    nrst <= 1'b0;
    standalonePin <= strap;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    go(3);
  endtask : rst
  task automatic endOfTest();
    $display("checks %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : endOfTest
  // main sequence: host mode, then standalone mode
  initial
  begin
    rst(1'b0);
    rd(poe_class_pkg::REG_STATUS);
    chk("status", 8'h07, got);
    chk("quarter", 8'h00, {7'h0, quarterOhm});
    det();
    go(14);
    rd(poe_class_pkg::REG_STATUS);
    chk("disabled", 8'h07, got);
    wr(poe_class_pkg::REG_CONTROL, 8'h01);
    for (c = 0; c < 5; c++)
    begin
      firstClass <= c[2:0];
      det();
      go(12);
      rd(poe_class_pkg::REG_STATUS);
      chk("class", {5'h0, c[2:0]}, got);
    end
    rd(poe_class_pkg::REG_HP_STATUS);
    chk("nopingpong", 8'h00, got);
    wr(poe_class_pkg::REG_CONTROL, 8'h03);
    c = $unsigned($random(seed)) % 4;
    firstClass <= 3'h4;
    secondClass <= c[2:0];
    det();
    go(10);
    chk("mark", 8'h01, {7'h0, markVoltageOn});
    go(20);
    rd(poe_class_pkg::REG_STATUS);
    chk("second", {5'h0, c[2:0]}, got);
    rd(poe_class_pkg::REG_HP_STATUS);
    chk("hpflag", 8'h01, got);
    firstClass <= 3'h3;
    det();
    go(30);
    rd(poe_class_pkg::REG_HP_STATUS);
    chk("type1", 8'h00, got);
    wr(poe_class_pkg::REG_CONTROL, 8'h09);
    firstClass <= 3'h1;
    det();
    go(12);
    rd(poe_class_pkg::REG_STATUS);
    chk("manualidle", 8'h03, got);
    wr(poe_class_pkg::REG_COMMAND, 8'h01);
    go(1);
    chk("classvolt", 8'h01, {7'h0, classVoltageOn});
    go(11);
    rd(poe_class_pkg::REG_STATUS);
    chk("manualrun", 8'h01, got);
    wr(poe_class_pkg::REG_COMMAND, 8'h02);
    go(1);
    chk("inrush", 8'h01, {7'h0, inrushRegulate});
    chk("inrushlim", 8'h00, hardCurrentLimit);
    go(20);
    rd(poe_class_pkg::REG_FAULT);
    chk("startflt", 8'h01, got);
    wr(poe_class_pkg::REG_FAULT, 8'h07);
    chargeOk <= 1'b1;
    wr(poe_class_pkg::REG_COMMAND, 8'h02);
    go(6);
    wr(poe_class_pkg::REG_LIMIT, 8'h40);
    go(2);
    chk("livelimit", 8'h40, hardCurrentLimit);
    overLimit <= 1'b1;
    go(8);
    overLimit <= 1'b0;
    rd(poe_class_pkg::REG_FAULT);
    chk("limflt", 8'h04, got);
    chk("offlimit", 8'h00, hardCurrentLimit);
    wr(poe_class_pkg::REG_FAULT, 8'h07);
    wr(poe_class_pkg::REG_COMMAND, 8'h02);
    go(6);
    // 6 up, 4 down, 2 up stays just under expiry only with slow decay
    overCut <= 1'b1;
    go(6);
    overCut <= 1'b0;
    go(4);
    overCut <= 1'b1;
    go(2);
    chk("decay", 8'h01, {7'h0, gateOn});
    // one more overload cycle reaches expiry only if the decay was at most four per cycle
    go(2);
    chk("expiry", 8'h00, {7'h0, gateOn});
    overCut <= 1'b0;
    rd(poe_class_pkg::REG_FAULT);
    chk("cutflt", 8'h02, got);
    rst(1'b1);
    wr(poe_class_pkg::REG_CONTROL, 8'h07);
    firstClass <= 3'h4;
    secondClass <= 3'h4;
    det();
    go(30);
    chk("type2on", 8'h01, {7'h0, gateOn});
    chk("lim850", 8'hC0, hardCurrentLimit);
    chk("cut4", 8'h40, {1'b0, overloadCutThreshold});
    chk("quarter1", 8'h01, {7'h0, quarterOhm});
    wr(poe_class_pkg::REG_COMMAND, 8'h04);
    go(2);
    chk("lim425", 8'h80, hardCurrentLimit);
    secondClass <= 3'h1;
    det();
    go(30);
    chk("badpair", 8'h01, restarts[7:0]);
    firstClass <= 3'h0;
    det();
    go(14);
    chk("class0", 8'h26, {1'b0, overloadCutThreshold});
    // shutdown drops a powered port and blocks a new classification
    shutdown <= 1'b1;
    go(2);
    chk("shutoff", 8'h00, {7'h0, gateOn});
    firstClass <= 3'h2;
    det();
    go(12);
    rd(poe_class_pkg::REG_STATUS);
    chk("shutclass", 8'h20, got);
    shutdown <= 1'b0;
    endOfTest();
  end
endmodule : poe_port_class_power_ctrl_tb_top
